// ===== hpc_top.sv
`timescale 1ns/1ps
// top level: pin synchronisers, host control crossing, two slots, interrupt
`include "hpc_map.svh"
module hpc_top (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic smb_clk,
   input wire logic [1:0] aux_rail_enable,
   input wire logic [1:0] main_rail_on,
   input wire logic [1:0] force_power_n,
   input wire logic [1:0] aux_high_current_sel,
   input wire logic addr_sel_bit0,
   input wire logic addr_sel_bit1,
   input wire logic addr_sel_bit2,
   input wire logic [1:0] aux_fault_event,
   input wire logic [1:0] main_fault_event,
   input wire logic [1:0] over_temp_event,
   input wire logic [1:0] rail3v3_out_sense,
   input wire logic [1:0] outputs_below_100mv,
   input wire logic smb_ctrl_write,
   input wire logic [1:0] smb_aux_on,
   input wire logic [1:0] smb_main_on,
   input wire logic [1:0] force_inhibit,
   input wire logic [1:0] smb_aux_high,
   input wire logic smb_int_mask,
   input wire logic smb_status_clear,
   output logic [1:0] aux_rail_out,
   output logic [1:0] main_rail_gate,
   output logic [1:0] discharge_en,
   output logic [1:0] aux_high_current,
   output logic [1:0] slot_fault_n_oe,
   output logic [1:0] power_good_n_oe,
   output logic int_n_oe,
   output logic [2:0] target_addr,
   output logic smb_ctrl_busy,
   output logic smb_host_mode,
   output logic [1:0] smb_fault,
   output logic [1:0] smb_power_good,
   output logic [1:0] slot_safe_off,
   output logic [1:0] smb_int_pending
);
   // ==========================================
   // reset release, one copy per clock domain
   logic rst_meta; // first stage, sys domain
   logic rst_sync; // reset used by sys logic
   logic smb_rst_meta; // first stage, host domain
   logic smb_rst; // reset used by host logic

   // reset asserts at once and leaves two edges later
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // same release in the host clock domain
   always_ff @(posedge smb_clk or negedge rst_n) begin
      if (!rst_n) begin
         smb_rst_meta <= 1'b0;
         smb_rst <= 1'b0;
      end else begin
         smb_rst_meta <= 1'b1;
         smb_rst <= smb_rst_meta;
      end
   end

   // ==========================================
   // pin synchronisers
   logic [`PIN_W-1:0] pin_q; // synchronised pin levels
   logic [1:0] aux_en_s, main_on_s, force_s, aux_hi_s;
   logic [1:0] aux_ev_s, main_ev_s, temp_s, good_s, below_s;
   logic [2:0] addr_s; // synchronised address straps

   // force-on is inverted ahead of the flops so reset reads it idle
   cdc_sync #(
      .WIDTH(`PIN_W)
   ) u_pin_sync (
      .clk(sys_clk),
      .rst_n(rst_sync),
      .d({outputs_below_100mv, rail3v3_out_sense, over_temp_event,
          main_fault_event, aux_fault_event,
          addr_sel_bit2, addr_sel_bit1, addr_sel_bit0,
          aux_high_current_sel, ~force_power_n, main_rail_on,
          aux_rail_enable}),
      .q(pin_q)
   );

   // named slices of the synchronised pins
   assign aux_en_s = pin_q[1:0];
   assign main_on_s = pin_q[3:2];
   assign force_s = pin_q[5:4];
   assign aux_hi_s = pin_q[7:6];
   assign addr_s = pin_q[10:8];
   assign aux_ev_s = pin_q[12:11];
   assign main_ev_s = pin_q[14:13];
   assign temp_s = pin_q[16:15];
   assign good_s = pin_q[18:17];
   assign below_s = pin_q[20:19];

   // ==========================================
   // address straps, caught once after reset release
   logic [2:0] init_cnt, next_init_cnt; // settle counter
   logic init_done, next_init_done; // straps captured
   logic [2:0] next_target_addr;

   // open strap pins are pulled up outside, so they read one
   always_comb begin
      next_init_cnt = init_cnt;
      next_init_done = init_done;
      next_target_addr = target_addr;
      if (!init_done) begin
         next_init_cnt = init_cnt + 3'h1;
         // wait out the synchroniser before trusting the straps
         if (init_cnt == `INIT_CYCLES) begin
            next_target_addr = addr_s;
            next_init_done = 1'b1;
         end
      end
   end

   // straps are frozen until the next reset
   always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         init_cnt <= 3'h0;
         init_done <= 1'b0;
         target_addr <= `ADDR_RESET;
      end else begin
         init_cnt <= next_init_cnt;
         init_done <= next_init_done;
         target_addr <= next_target_addr;
      end
   end

   // ==========================================
   // host side: control word request and status clear
   logic [`CTRL_W-1:0] smb_word, next_smb_word; // held control word
   logic smb_req, next_smb_req; // request toggle
   logic smb_clr, next_smb_clr; // status clear toggle
   logic next_smb_busy;
   logic smb_ack_s; // acknowledge toggle seen in host domain

   // a write while busy is dropped; the word must stay still until acked
   always_comb begin
      next_smb_word = smb_word;
      next_smb_req = smb_req;
      if (smb_ctrl_write && !smb_ctrl_busy) begin
         next_smb_word = {smb_int_mask, smb_aux_high, force_inhibit,
                          smb_main_on, smb_aux_on};
         next_smb_req = !smb_req;
      end
      next_smb_clr = smb_clr ^ smb_status_clear;
      next_smb_busy = next_smb_req ^ smb_ack_s;
   end

   // host domain registers
   always_ff @(posedge smb_clk or negedge smb_rst) begin
      if (!smb_rst) begin
         smb_word <= `CTRL_RESET;
         smb_req <= 1'b0;
         smb_clr <= 1'b0;
         smb_ctrl_busy <= 1'b0;
      end else begin
         smb_word <= next_smb_word;
         smb_req <= next_smb_req;
         smb_clr <= next_smb_clr;
         smb_ctrl_busy <= next_smb_busy;
      end
   end

   // ==========================================
   // sys side: take the word, detect the clear
   logic req_s; // request toggle in sys domain
   logic clr_s; // clear toggle in sys domain
   logic ack, next_ack; // acknowledge toggle
   logic clr_seen, next_clr_seen; // last clear toggle taken
   logic clr_pulse; // one-cycle status clear
   logic [`CTRL_W-1:0] ctrl_word, next_ctrl_word; // live control bits
   logic host_mode, next_host_mode; // 1 once host wrote control
   logic int_mask; // interrupt mask bit
   logic next_int;

   // toggles cross on two flops each
   cdc_sync #(
      .WIDTH(2)
   ) u_req_sync (
      .clk(sys_clk),
      .rst_n(rst_sync),
      .d({smb_clr, smb_req}),
      .q({clr_s, req_s})
   );

   // acknowledge returns to the host domain
   cdc_sync #(
      .WIDTH(1)
   ) u_ack_sync (
      .clk(smb_clk),
      .rst_n(smb_rst),
      .d(ack),
      .q(smb_ack_s)
   );

   assign clr_pulse = clr_s ^ clr_seen;
   assign int_mask = ctrl_word[`CW_MASK];

   // a taken control write also leaves direct pin mode until the next reset
   always_comb begin
      next_ack = ack;
      next_ctrl_word = ctrl_word;
      next_host_mode = host_mode;
      if (req_s != ack) begin
         next_ack = req_s;
         next_ctrl_word = smb_word;
         next_host_mode = 1'b1;
      end
      next_clr_seen = clr_s;
   end

   // sys domain control registers
   always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         ack <= 1'b0;
         ctrl_word <= `CTRL_RESET;
         host_mode <= 1'b0;
         clr_seen <= 1'b0;
      end else begin
         ack <= next_ack;
         ctrl_word <= next_ctrl_word;
         host_mode <= next_host_mode;
         clr_seen <= next_clr_seen;
      end
   end

   // ==========================================
   // the two slot controllers
   logic [1:0] pend; // interrupt pending per slot
   logic [1:0] fault, pgood, safe;
   genvar s;
   generate
      for (s = 0; s < `SLOT_COUNT; s++) begin : g_slot
         slot_if sif();
         assign sif.aux_en = aux_en_s[s];
         // main-on reads high until the straps settle, so a pin held at reset cannot arm
         assign sif.main_on = main_on_s[s] || !init_done;
         assign sif.force_req = force_s[s];
         assign sif.aux_hi_pin = aux_hi_s[s];
         assign sif.aux_ev = aux_ev_s[s];
         assign sif.main_ev = main_ev_s[s];
         assign sif.temp_ev = temp_s[s];
         assign sif.good33 = good_s[s];
         assign sif.below100 = below_s[s];
         assign sif.mode = host_mode;
         assign sif.smb_aux = ctrl_word[`CW_AUX + s];
         assign sif.smb_main = ctrl_word[`CW_MAIN + s];
         assign sif.inhibit = ctrl_word[`CW_INHIB + s];
         assign sif.smb_aux_hi = ctrl_word[`CW_AUXHI + s];
         assign sif.clr = clr_pulse;
         // one identical, independent controller per slot
         slot_ctrl u_slot (
            .clk(sys_clk),
            .rst_n(rst_sync),
            .bus(sif.ctrl)
         );
         assign aux_rail_out[s] = sif.aux_on;
         assign main_rail_gate[s] = sif.main_gate;
         assign discharge_en[s] = sif.bleed;
         assign aux_high_current[s] = sif.aux_hi;
         assign slot_fault_n_oe[s] = sif.fault;
         assign power_good_n_oe[s] = sif.pgood;
         assign pend[s] = sif.pend;
         assign fault[s] = sif.fault;
         assign pgood[s] = sif.pgood;
         assign safe[s] = sif.safe_off;
      end
   endgenerate

   // ==========================================
   // shared interrupt
   // either slot may pull the shared line; the mask holds it released
   always_comb begin
      next_int = (|pend) && !int_mask;
   end

   // interrupt register
   always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         int_n_oe <= 1'b0;
      end else begin
         int_n_oe <= next_int;
      end
   end

   // ==========================================
   // status back to the host domain
   // bits cross one by one; a status read may see them skewed by a cycle
   cdc_sync #(
      .WIDTH(`STAT_W)
   ) u_stat_sync (
      .clk(smb_clk),
      .rst_n(smb_rst),
      .d({host_mode, pend, safe, pgood, fault}),
      .q({smb_host_mode, smb_int_pending, slot_safe_off, smb_power_good, smb_fault})
   );

   // ==========================================
   // checks
   a_int_assert: assert property (@(posedge sys_clk) disable iff (!rst_sync)
      (|pend) && !int_mask |=> int_n_oe) else $error("interrupt not driven");
   a_int_masked: assert property (@(posedge sys_clk) disable iff (!rst_sync)
      int_mask |=> !int_n_oe) else $error("masked interrupt driven");
   a_int_hold: assert property (@(posedge sys_clk) disable iff (!rst_sync)
      int_n_oe && !int_mask && !clr_pulse && !$past(clr_pulse) |=> int_n_oe
      ##1 (int_n_oe || clr_pulse || int_mask)) else $error("interrupt dropped early");
   a_addr_frozen: assert property (@(posedge sys_clk) disable iff (!rst_sync)
      init_done |=> $stable(target_addr)) else $error("address moved");
   a_mode_sticky: assert property (@(posedge sys_clk) disable iff (!rst_sync)
      (req_s != ack) |=> host_mode ##1 host_mode) else $error("mode not kept");
endmodule // hpc_top

// ===== hpc_map.svh
// constants, field positions and reset values of the dual-slot power control block
`ifndef HPC_MAP_SVH
`define HPC_MAP_SVH
`define SLOT_COUNT 2
`define PIN_W 21
`define INIT_CYCLES 3'h3
`define ADDR_RESET 3'h0
`define CTRL_W 9
`define CTRL_RESET 9'h000
`define CW_AUX 0
`define CW_MAIN 2
`define CW_INHIB 4
`define CW_AUXHI 6
`define CW_MASK 8
`define STAT_W 9
`endif

// ===== hpc_pkg.sv
// shared types of the dual-slot power control block
package hpc_pkg;
   // main rail sequence of one slot
   typedef enum logic [1:0] {
      st_off = 2'b00,  // rails off, discharging
      st_on = 2'b01,   // rails on
      st_safe = 2'b10  // discharged, safe to remove
   } main_state_type;
endpackage

// ===== slot_if.sv
`timescale 1ns/1ps
// signals between the top level and one slot controller
interface slot_if;
   logic aux_en;     // synchronised aux enable pin
   logic main_on;    // synchronised main-on pin
   logic force_req;  // synchronised force-on, active high
   logic aux_hi_pin; // synchronised high-current select
   logic aux_ev;     // aux rail fault event
   logic main_ev;    // main rail fault event
   logic temp_ev;    // over-temperature, shuts the slot down
   logic good33;     // 3.3 V output above power-good level
   logic below100;   // all outputs below 100 mV
   logic mode;       // 1: host register control
   logic smb_aux;    // host aux enable
   logic smb_main;   // host main enable
   logic inhibit;    // host force-on inhibit
   logic smb_aux_hi; // host high-current select
   logic clr;        // one-cycle status clear
   logic aux_on;     // aux switch drive
   logic main_gate;  // main gate drive
   logic bleed;      // discharge path enable
   logic aux_hi;     // high-current limit select
   logic fault;      // latched fault
   logic pgood;      // power good
   logic safe_off;   // slot safe to remove
   logic pend;       // interrupt pending
   modport ctrl (
      input aux_en, main_on, force_req, aux_hi_pin, aux_ev, main_ev, temp_ev,
      input good33, below100, mode, smb_aux, smb_main, inhibit, smb_aux_hi, clr,
      output aux_on, main_gate, bleed, aux_hi, fault, pgood, safe_off, pend
   );
   modport top (
      output aux_en, main_on, force_req, aux_hi_pin, aux_ev, main_ev, temp_ev,
      output good33, below100, mode, smb_aux, smb_main, inhibit, smb_aux_hi, clr,
      input aux_on, main_gate, bleed, aux_hi, fault, pgood, safe_off, pend
   );
endinterface // slot_if

// ===== cdc_sync.sv
`timescale 1ns/1ps
// two-flop level synchroniser, one pair per bit
module cdc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   // first stage, read by the second stage only
   logic [WIDTH-1:0] meta;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         // =====================================
         // synchroniser pair for one bit
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta[i] <= 1'b0;
               q[i] <= 1'b0;
            end else begin
               meta[i] <= d[i];
               q[i] <= meta[i];
            end
         end
      end
   endgenerate
endmodule // cdc_sync

// ===== slot_ctrl.sv
`timescale 1ns/1ps
// per-slot rail control, fault latches and discharge sequence
module slot_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   slot_if.ctrl bus
);
   logic cmd_aux;   // selected aux command
   logic cmd_main;  // selected main command
   logic force_act; // force-on not inhibited
   logic aux_req;   // aux switch wanted
   logic main_req;  // main rails wanted
   logic armed, next_armed; // main-on seen low since reset
   logic aux_fault, next_aux_fault;
   logic main_fault, next_main_fault;
   logic next_pend, next_aux_on, next_bleed, next_aux_hi;
   logic next_fault, next_pgood, next_safe;
   hpc_pkg::main_state_type state, next_state;

   // ==========================================
   // next-state logic
   always_comb begin
      // pins steer in direct mode, host bits after a control write
      cmd_aux = bus.mode ? bus.smb_aux : bus.aux_en;
      cmd_main = bus.mode ? bus.smb_main : bus.main_on;
      force_act = bus.force_req && !bus.inhibit;
      // a main-on already high at reset must drop once first
      next_armed = armed || !cmd_main;
      // set wins over clear so no event is lost
      if (bus.aux_ev || bus.temp_ev) begin
         next_aux_fault = 1'b1;
      end else if (!cmd_aux) begin
         next_aux_fault = 1'b0;
      end else begin
         next_aux_fault = aux_fault;
      end
      if (bus.main_ev || bus.temp_ev) begin
         next_main_fault = 1'b1;
      end else if (!cmd_main) begin
         next_main_fault = 1'b0;
      end else begin
         next_main_fault = main_fault;
      end
      // thermal shutdown beats force-on
      aux_req = ((cmd_aux && !aux_fault) || force_act) && !bus.temp_ev;
      main_req = ((cmd_main && armed && !main_fault) || force_act)
                 && !bus.temp_ev;
      case (state)
         hpc_pkg::st_on: begin
            next_state = main_req ? hpc_pkg::st_on : hpc_pkg::st_off;
         end
         hpc_pkg::st_off: begin
            // discharged once every output is below 100 mV
            if (main_req) begin
               next_state = hpc_pkg::st_on;
            end else if (bus.below100) begin
               next_state = hpc_pkg::st_safe;
            end else begin
               next_state = hpc_pkg::st_off;
            end
         end
         hpc_pkg::st_safe: begin
            next_state = main_req ? hpc_pkg::st_on : hpc_pkg::st_safe;
         end
         default: begin
            next_state = hpc_pkg::st_off;
         end
      endcase
      next_aux_on = aux_req;
      next_bleed = (next_state != hpc_pkg::st_on);
      next_aux_hi = bus.aux_hi_pin || bus.smb_aux_hi;
      next_fault = next_aux_fault || next_main_fault;
      next_pgood = (next_state == hpc_pkg::st_on) && bus.good33
                   && !next_main_fault;
      next_safe = (next_state == hpc_pkg::st_safe);
      next_pend = bus.aux_ev || bus.main_ev || bus.temp_ev
                  || (bus.pend && !bus.clr);
   end

   // ==========================================
   // registers; reset clears all but bleed, which it sets, rails off
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= hpc_pkg::st_off;
         armed <= 1'b0;
         aux_fault <= 1'b0;
         main_fault <= 1'b0;
         bus.aux_on <= 1'b0;
         bus.main_gate <= 1'b0;
         bus.bleed <= 1'b1;
         bus.aux_hi <= 1'b0;
         bus.fault <= 1'b0;
         bus.pgood <= 1'b0;
         bus.safe_off <= 1'b0;
         bus.pend <= 1'b0;
      end else begin
         state <= next_state;
         armed <= next_armed;
         aux_fault <= next_aux_fault;
         main_fault <= next_main_fault;
         bus.aux_on <= next_aux_on;
         bus.main_gate <= (next_state == hpc_pkg::st_on);
         bus.bleed <= next_bleed;
         bus.aux_hi <= next_aux_hi;
         bus.fault <= next_fault;
         bus.pgood <= next_pgood;
         bus.safe_off <= next_safe;
         bus.pend <= next_pend;
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence main_drop;
      bus.main_gate ##1 !bus.main_gate;
   endsequence
   a_aux_follow: assert property (!bus.mode && bus.aux_en && !aux_fault && !bus.temp_ev
      |=> bus.aux_on) else $error("aux rail not on");
   a_aux_release: assert property (!bus.mode && !bus.aux_en && !force_act
      |=> !bus.aux_on) else $error("aux rail not off");
   a_aux_clear: assert property (!bus.mode && !bus.aux_en && !bus.aux_ev && !bus.temp_ev
      |=> !aux_fault) else $error("aux fault not cleared");
   a_main_clear: assert property (!bus.mode && !bus.main_on && !bus.main_ev
      && !bus.temp_ev |=> !main_fault) else $error("main fault not cleared");
   a_main_release: assert property (!bus.mode && !bus.main_on && !force_act
      |=> !bus.main_gate) else $error("main rails not off");
   a_main_armed: assert property (!armed && !force_act
      |=> !bus.main_gate) else $error("main on before arming");
   a_force_on: assert property (bus.force_req && !bus.inhibit && !bus.temp_ev
      |=> bus.aux_on && bus.main_gate) else $error("force-on ignored");
   a_thermal_off: assert property (bus.temp_ev
      |=> !bus.aux_on && !bus.main_gate && bus.fault) else $error("thermal");
   a_drop_bleed: assert property (main_drop |-> bus.bleed ##1 (bus.bleed || bus.main_gate))
      else $error("no discharge after off");
   a_safe_set: assert property (state == hpc_pkg::st_off && bus.below100 && !main_req
      |=> bus.safe_off) else $error("safe-off not set");
   a_pend_hold: assert property (bus.pend && !bus.clr
      |=> bus.pend) else $error("pending lost");
endmodule // slot_ctrl

// ===== host_model.sv
// host-side model: control word writes and status clears on the link clock
`timescale 1ns/1ps
module host_model (
   input wire logic smb_clk,
   output logic smb_ctrl_write,
   output logic [8:0] word,
   output logic smb_status_clear
);
   // ==========
   // idle levels until the host speaks
   initial begin
      smb_ctrl_write = 1'b0;
      word = 9'h000;
      smb_status_clear = 1'b0;
   end
   // one-cycle write pulse; data is scrambled once it is no longer valid
   task automatic write(input logic [8:0] w);
      @(posedge smb_clk);
      #1;
      word = w;
      smb_ctrl_write = 1'b1;
      @(posedge smb_clk);
      #1;
      smb_ctrl_write = 1'b0;
      word = ~w;
   endtask
   // one-cycle status clear; this is what releases a held interrupt
   task automatic clear();
      @(posedge smb_clk);
      #1;
      smb_status_clear = 1'b1;
      @(posedge smb_clk);
      #1;
      smb_status_clear = 1'b0;
   endtask
endmodule // host_model

// ===== dual_slot_power_control_pins_tb.sv
// self-checking bench of the dual-slot power control block
`timescale 1ns/1ps
module dual_slot_power_control_pins_tb;
   // ==========
   // clocks, pins and results
   logic sys_clk = 1'b0, smb_clk = 1'b0, rst_n = 1'b0;
   logic [1:0] aux_rail_enable = 2'h0, main_rail_on = 2'h0, aux_high_current_sel = 2'h0;
   logic [1:0] aux_fault_event = 2'h0, main_fault_event = 2'h0, rail3v3_out_sense = 2'h0;
   logic [1:0] outputs_below_100mv = 2'h0;
   logic [2:0] addr = 3'h5; // bit1 grounded, others open
   logic smb_ctrl_write, smb_status_clear, int_n_oe, smb_ctrl_busy, smb_host_mode;
   logic [8:0] word;
   logic [1:0] aux_rail_out, main_rail_gate, discharge_en, aux_high_current, slot_fault_n_oe;
   logic [1:0] power_good_n_oe, slot_safe_off, smb_fault, smb_power_good, smb_int_pending;
   logic [1:0] force_power_n = 2'h3, over_temp_event = 2'h0;
   logic [2:0] target_addr;
   int failures = 0, compares = 0;
   always #25 sys_clk = ~sys_clk;
   always #16 smb_clk = ~smb_clk; // 32 ns, phase unrelated
   // every pin of the block is driven and every output is watched
   hpc_top hpc_top_i (.sys_clk, .rst_n, .smb_clk, .aux_rail_enable, .main_rail_on,
      .force_power_n, .aux_high_current_sel, .addr_sel_bit0(addr[0]),
      .addr_sel_bit1(addr[1]), .addr_sel_bit2(addr[2]), .aux_fault_event,
      .main_fault_event, .over_temp_event, .rail3v3_out_sense, .outputs_below_100mv,
      .smb_ctrl_write, .smb_aux_on(word[1:0]), .smb_main_on(word[3:2]),
      .force_inhibit(word[5:4]), .smb_aux_high(word[7:6]), .smb_int_mask(word[8]),
      .smb_status_clear, .aux_rail_out, .main_rail_gate, .discharge_en, .aux_high_current,
      .slot_fault_n_oe, .power_good_n_oe, .int_n_oe, .target_addr, .smb_ctrl_busy,
      .smb_host_mode, .smb_fault, .smb_power_good, .slot_safe_off, .smb_int_pending);
   host_model host_model_i (.smb_clk, .smb_ctrl_write, .word, .smb_status_clear);
   // ==========
   // shared helpers
   task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // settle time covers the 3-edge sync path with margin
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic give_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ==========
   // scenarios
   task automatic straps_test();
      chk("target_addr", 9'h005, 9'(target_addr));
      addr = 3'h2;
      cyc(8);
      chk("target_addr held", 9'h005, 9'(target_addr));
      $display("straps test done");
   endtask
   task automatic pin_test();
      aux_rail_enable = 2'h2;
      aux_high_current_sel = 2'h1;
      main_rail_on = 2'h1;
      rail3v3_out_sense = 2'h1;
      cyc(8);
      chk("aux_rail_out", 9'h002, 9'(aux_rail_out));
      chk("aux_high_current", 9'h001, 9'(aux_high_current));
      chk("main_rail_gate", 9'h001, 9'(main_rail_gate));
      chk("discharge_en", 9'h002, 9'(discharge_en));
      chk("power_good_n_oe", 9'h001, 9'(power_good_n_oe));
      chk("smb_power_good", 9'h001, 9'(smb_power_good));
      aux_rail_enable = 2'h0;
      main_rail_on = 2'h0;
      outputs_below_100mv = 2'h1;
      cyc(12);
      chk("aux off", 9'h000, 9'(aux_rail_out));
      chk("main off", 9'h000, 9'(main_rail_gate));
      chk("discharge_en", 9'h003, 9'(discharge_en));
      chk("slot_safe_off", 9'h001, 9'(slot_safe_off));
      $display("pin test done");
   endtask
   // fault latched after the event ends, cleared by the rail's own enable only
   task automatic fault_test(input int s, input bit aux);
      aux_rail_enable[s] = 1'b1;
      main_rail_on[s] = 1'b1;
      cyc(8);
      if (aux) aux_fault_event[s] = 1'b1;
      else main_fault_event[s] = 1'b1;
      cyc(4);
      aux_fault_event = 2'h0;
      main_fault_event = 2'h0;
      cyc(8);
      chk("slot_fault_n_oe", 9'(s + 1), 9'(slot_fault_n_oe));
      chk("int_n_oe", 9'h001, 9'(int_n_oe));
      if (aux) aux_rail_enable[s] = 1'b0;
      else main_rail_on[s] = 1'b0;
      cyc(8);
      chk("fault cleared", 9'h000, 9'(slot_fault_n_oe));
      chk("int held", 9'h001, 9'(int_n_oe));
      host_model_i.clear();
      cyc(12);
      chk("int released", 9'h000, 9'(int_n_oe));
      aux_rail_enable = 2'h0;
      main_rail_on = 2'h0;
      cyc(8);
      $display("fault test done");
   endtask
   // force-on with pins low, then thermal shutdown overriding it
   task automatic force_test();
      force_power_n = 2'h2;
      cyc(8);
      chk("force rails", 9'h005, 9'({aux_rail_out, main_rail_gate}));
      over_temp_event = 2'h1;
      cyc(8);
      chk("thermal rails", 9'h000, 9'({aux_rail_out, main_rail_gate}));
      chk("thermal fault", 9'h001, 9'(slot_fault_n_oe));
      chk("smb_fault", 9'h001, 9'(smb_fault));
      chk("smb_int_pending", 9'h001, 9'(smb_int_pending));
      chk("thermal int", 9'h001, 9'(int_n_oe));
      over_temp_event = 2'h0;
      force_power_n = 2'h3;
      cyc(8);
      chk("thermal cleared", 9'h000, 9'(slot_fault_n_oe));
      host_model_i.clear();
      cyc(12);
      chk("pending cleared", 9'h000, 9'(smb_int_pending));
      chk("thermal int released", 9'h000, 9'(int_n_oe));
      $display("force test done");
   endtask
   // second reset with main-on already high: rails stay off until main-on drops
   task automatic reset_test();
      main_fault_event = 2'h0;
      force_power_n = 2'h3;
      main_rail_on = 2'h3;
      rst_n = 1'b0;
      cyc(4);
      rst_n = 1'b1;
      cyc(12);
      chk("main after reset", 9'h000, 9'(main_rail_gate));
      chk("mode after reset", 9'h000, 9'(smb_host_mode));
      chk("target_addr new", 9'h002, 9'(target_addr));
      main_rail_on = 2'h0;
      cyc(8);
      main_rail_on = 2'h3;
      cyc(8);
      chk("main rearmed", 9'h003, 9'(main_rail_gate));
      $display("reset test done");
   endtask
   // host mode is sticky until reset, so this runs after the pin scenarios and before reset_test
   task automatic host_test();
      int i;
      host_model_i.write(9'h1A5);
      chk("smb_ctrl_busy", 9'h001, 9'(smb_ctrl_busy));
      for (i = 0; i < 40 && smb_ctrl_busy !== 1'b0; i++) cyc(1);
      if (i == 40) begin
         failures++;
         give_verdict();
      end
      force_power_n = 2'h1;
      cyc(8);
      chk("smb_host_mode", 9'h001, 9'(smb_host_mode));
      chk("host rails", 9'h005, 9'({aux_rail_out, main_rail_gate}));
      chk("host aux_high", 9'h003, 9'(aux_high_current));
      main_fault_event = 2'h1;
      cyc(8);
      chk("fault pin", 9'h001, 9'(slot_fault_n_oe));
      chk("masked int", 9'h000, 9'(int_n_oe));
      $display("host test done");
   endtask
   // ==========
   // main sequence
   initial begin
      repeat (6) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      cyc(12);
      straps_test();
      pin_test();
      fault_test(0, 1'b0);
      fault_test(1, 1'b1);
      force_test();
      host_test();
      reset_test();
      give_verdict();
   end
endmodule // dual_slot_power_control_pins_tb
